/* File: common/sscs_regs.svh */
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 125 MHz core clock, AXI4-Lite byte addresses
// Notes:   Recovery cycle count is derived from the printed sleep recovery time
`ifndef SSCS_REGS_SVH
`define SSCS_REGS_SVH
// ====================
// Register offsets
`define SSCS_CTRL_OFS     8'h00
`define SSCS_STAT_OFS     8'h04
`define SSCS_CAPT_OFS     8'h08
`define SSCS_IMPD_OFS     8'h0C
// ====================
// Fields and reset values
`define SSCS_CTRL_CALEN   0
`define SSCS_CTRL_TGT_LSB 8
`define SSCS_STAT_STICKY  3
`define SSCS_CTRL_RST     32'h0000_2001
`define SSCS_IMP_RST      6'h20
// ====================
// Geometry
`define SSCS_AW           8
`define SSCS_DW           32
`define SSCS_LANES        4
`define SSCS_CAP_DEPTH    8
// ====================
// Timing
`define SSCS_CLK_NS       8
`define SSCS_SLEEP_REC_NS 20
`define SSCS_REC_CYC      ((`SSCS_SLEEP_REC_NS + `SSCS_CLK_NS - 1) / `SSCS_CLK_NS)
`define SSCS_CAL_CYCLES   8192
`define SSCS_PRE_DESEL    2
`define SSCS_POST_DESEL   32
`endif

/* File: common/sscs_pkg.sv */
// Purpose: Types shared by the SRAM command and sleep control
// Assumes: Nothing
// Notes:   Command decode follows the pin truth table
`default_nettype none
package sscs_pkg;
    typedef enum logic [1:0] {
        SSCS_DESEL = 2'b00,
        SSCS_READ  = 2'b01,
        SSCS_WRITE = 2'b10,
        SSCS_ABORT = 2'b11
    } sscs_op_t;
    typedef enum logic [1:0] {
        SSCS_RUN     = 2'b00,
        SSCS_SLEEP   = 2'b01,
        SSCS_RECOVER = 2'b10
    } sscs_pwr_t;
    // Select, write enable and byte enables to operation
    function automatic sscs_op_t sscs_decode(input logic cs_n, input logic we_n,
                                             input logic [3:0] be_n);
        if (cs_n)
            return SSCS_DESEL;
        if (we_n)
            return SSCS_READ;
        return (&be_n) ? SSCS_ABORT : SSCS_WRITE;
    endfunction
endpackage
`default_nettype wire

/* File: common/sscs_stream_if.sv */
// Purpose: Valid/ready word stream between internal modules
// Assumes: Single clock
// Notes:   One word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface sscs_stream_if #(parameter int W = 32) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hdl/sscs_fifo.sv */
// Purpose: Capture FIFO for written data words
// Assumes: Same clock on both sides
// Notes:   Ready low when full, valid low when empty
`timescale 1ns/1ps
`default_nettype none
module sscs_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic   clk,
    input  wire logic   arst_n,
    sscs_stream_if.snk  wr,
    sscs_stream_if.src  rd
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]   cnt_q;
    wire           push;
    wire           pop;

    // ====================
    // Flags and handshakes
    assign wr.ready = (cnt_q != (PW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem_q[rp_q];
    assign push     = wr.valid & wr.ready;
    assign pop      = rd.valid & rd.ready;

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push)
            mem_q[wp_q] <= wr.data;
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= push ? PW'(wp_q + 1'b1) : wp_q;
            rp_q  <= pop ? PW'(rp_q + 1'b1) : rp_q;
            cnt_q <= (PW+1)'(cnt_q + push - pop);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sscs_mem.sv */
// Purpose: Byte-lane memory array with registered read data
// Assumes: One write and one read port on one clock
// Notes:   Array has no reset, so contents survive reset and sleep
`timescale 1ns/1ps
`default_nettype none
`include "sscs_regs.svh"
module sscs_mem (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    we,
    input  wire logic [`SSCS_AW-1:0]     waddr,
    input  wire logic [`SSCS_LANES-1:0]  wbe,
    input  wire logic [`SSCS_DW-1:0]     wdata,
    input  wire logic                    re,
    input  wire logic [`SSCS_AW-1:0]     raddr,
    output var  logic [`SSCS_DW-1:0]     rdata
);
    wire same = we & (waddr == raddr);

    // ====================
    // One array per byte lane, write-first on a clash
    for (genvar b = 0; b < `SSCS_LANES; b++) begin : g_lane
        logic [7:0] arr [2**`SSCS_AW];
        always_ff @(posedge clk) begin
            if (we && wbe[b])
                arr[waddr] <= wdata[8*b +: 8];
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n)
                rdata[8*b +: 8] <= 8'h00;
            else if (re)
                rdata[8*b +: 8] <= (same && wbe[b]) ? wdata[8*b +: 8] : arr[raddr];
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sscs_top.sv */
// Purpose: Command decode, sleep and mode control of a pipelined SRAM
// Assumes: Controller logic drives commands on clk; registers on AXI4-Lite
// Notes:   Output enable and sleep pins also gate the drivers directly
`timescale 1ns/1ps
`default_nettype none
`include "sscs_regs.svh"
module sscs_top #(
    parameter int CAL_CYCLES = `SSCS_CAL_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   chip_select_n,
    input  wire logic                   sync_write_enable_n,
    input  wire logic [`SSCS_LANES-1:0] byte_lane_write_enable_n,
    input  wire logic [`SSCS_AW-1:0]    sram_addr,
    input  wire logic [`SSCS_DW-1:0]    dq_in,
    output var  logic [`SSCS_DW-1:0]    dq_out,
    output var  logic                   dq_oe_n,
    input  wire logic                   output_enable_n,
    input  wire logic                   sleep_request,
    input  wire logic                   late_select_mode_pin,
    output var  logic [5:0]             impedance_code,
    output var  logic                   standby
);
    // ====================
    // Declarations
    sscs_pkg::sscs_op_t  op_raw, op;
    sscs_pkg::sscs_pwr_t pwr_q, pwr_d;
    logic [1:0]  s1_q, s2_q, s3_q, lvl_q;
    logic [4:0]  arm_q;
    logic        mode_prev_q, drive_q, wr_pend_q, sw_q, cal_done_q;
    logic [`SSCS_AW-1:0]    wr_addr_q;
    logic [`SSCS_LANES-1:0] wr_be_q;
    logic [1:0]  rec_cnt_q;
    logic [5:0]  desel_run_q, sw_cnt_q, imp_q;
    logic [13:0] cal_cnt_q;
    logic [31:0] ctrl_q, aw_data_q;
    logic [3:0]  w_strb_q;
    logic [7:0]  aw_addr_q;
    logic        aw_have_q, w_have_q;
    logic [2:0]  sticky_q;
    wire         sleep_s, mode_s, awake, mode_chg, mem_we, upd_ok, wr_go, ar_go;
    wire  [1:0]  agree;
    wire  [2:0]  st_set, st_clr;
    wire  [3:0]  wr_hot, rd_hot;
    wire  [5:0]  tgt;
    wire  [31:0] stat_w, rd_mux;

    sscs_stream_if #(.W(`SSCS_DW)) cap_in ();
    sscs_stream_if #(.W(`SSCS_DW)) cap_out ();

    // One-hot register decode of a byte address
    function automatic logic [3:0] reg_hot(input logic [7:0] a);
        return {a == `SSCS_IMPD_OFS, a == `SSCS_CAPT_OFS,
                a == `SSCS_STAT_OFS, a == `SSCS_CTRL_OFS};
    endfunction

    // ====================
    // Pin synchronisers, index 0 sleep, index 1 mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= 2'h0;
            s2_q  <= 2'h0;
            s3_q  <= 2'h0;
            lvl_q <= 2'h0;
            arm_q <= 5'h00;
        end else begin
            s1_q  <= {late_select_mode_pin, sleep_request};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (lvl_q & ~agree) | (s3_q & agree);
            arm_q <= {arm_q[3:0], 1'b1};
        end
    end

    // Level moves once stages two and three agree
    assign agree   = ~(s2_q ^ s3_q);
    assign sleep_s = lvl_q[0];
    assign mode_s  = lvl_q[1];

    // ====================
    // Command decode
    // clock-edge sampling
    assign op_raw = sscs_pkg::sscs_decode(chip_select_n, sync_write_enable_n,
                                          byte_lane_write_enable_n);
    assign awake  = ~sleep_s & (pwr_q != sscs_pkg::SSCS_SLEEP);
    assign op     = awake ? op_raw : sscs_pkg::SSCS_DESEL;

    // ====================
    // Data pipeline: read drive and late write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_q   <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_be_q   <= '0;
        end else begin
            drive_q   <= (op == sscs_pkg::SSCS_READ);
            wr_pend_q <= (op == sscs_pkg::SSCS_WRITE) || (op == sscs_pkg::SSCS_ABORT);
            wr_addr_q <= sram_addr;
            wr_be_q   <= ~byte_lane_write_enable_n;
        end
    end

    assign dq_oe_n = ~(drive_q & ~output_enable_n & ~sleep_request & ~sleep_s);
    assign standby = sleep_request | sleep_s;
    assign mem_we  = wr_pend_q & (|wr_be_q);

    // array is never reset or cleared
    sscs_mem u_mem (
        .clk    (clk),
        .arst_n (arst_n),
        .we     (mem_we),
        .waddr  (wr_addr_q),
        .wbe    (wr_be_q),
        .wdata  (dq_in),
        .re     (op == sscs_pkg::SSCS_READ),
        .raddr  (sram_addr),
        .rdata  (dq_out)
    );

    // Capture of stored data words for software
    assign cap_in.valid = mem_we;
    assign cap_in.data  = dq_in;

    sscs_fifo #(.W(`SSCS_DW), .DEPTH(`SSCS_CAP_DEPTH)) u_cap (
        .clk    (clk),
        .arst_n (arst_n),
        .wr     (cap_in),
        .rd     (cap_out)
    );

    // ====================
    // Power state
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            sscs_pkg::SSCS_RUN:     if (sleep_s) pwr_d = sscs_pkg::SSCS_SLEEP;
            sscs_pkg::SSCS_SLEEP:   if (!sleep_s) pwr_d = sscs_pkg::SSCS_RECOVER;
            sscs_pkg::SSCS_RECOVER: begin
                if (sleep_s)
                    pwr_d = sscs_pkg::SSCS_SLEEP;
                else if (rec_cnt_q == 2'(`SSCS_REC_CYC - 1))
                    pwr_d = sscs_pkg::SSCS_RUN;
            end
            default:                pwr_d = sscs_pkg::SSCS_RUN;
        endcase
    end

    // State and recovery count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q     <= sscs_pkg::SSCS_RUN;
            rec_cnt_q <= 2'h0;
        end else begin
            pwr_q     <= pwr_d;
            rec_cnt_q <= (pwr_q == sscs_pkg::SSCS_RECOVER) ? 2'(rec_cnt_q + 1'b1) : 2'h0;
        end
    end

    // ====================
    // Late-select mode change tracking, held off until the synced level settles
    assign mode_chg = arm_q[4] & (mode_s ^ mode_prev_q);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_prev_q <= 1'b0;
            desel_run_q <= 6'h00;
            sw_q        <= 1'b0;
            sw_cnt_q    <= 6'h00;
        end else begin
            mode_prev_q <= mode_s;
            if (op != sscs_pkg::SSCS_DESEL)
                desel_run_q <= 6'h00;
            else if (desel_run_q != 6'h3F)
                desel_run_q <= 6'(desel_run_q + 1'b1);
            if (mode_chg) begin
                sw_q     <= 1'b1;
                sw_cnt_q <= 6'h00;
            end else if (sw_q && op != sscs_pkg::SSCS_DESEL) begin
                sw_cnt_q <= 6'h00;
            end else if (sw_q) begin
                sw_q     <= (sw_cnt_q != 6'(`SSCS_POST_DESEL - 1));
                sw_cnt_q <= 6'(sw_cnt_q + 1'b1);
            end
        end
    end

    // ====================
    // Impedance calibration
    // update window
    assign upd_ok = ctrl_q[`SSCS_CTRL_CALEN] & dq_oe_n & ~drive_q
                    & (op != sscs_pkg::SSCS_READ);
    assign tgt    = ctrl_q[`SSCS_CTRL_TGT_LSB +: 6];
    assign impedance_code = imp_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_cnt_q  <= 14'h0000;
            cal_done_q <= 1'b0;
            imp_q      <= `SSCS_IMP_RST;
        end else begin
            if (!cal_done_q)
                cal_cnt_q <= 14'(cal_cnt_q + 1'b1);
            cal_done_q <= cal_done_q | (cal_cnt_q == 14'(CAL_CYCLES - 1));
            if (upd_ok && imp_q < tgt)
                imp_q <= 6'(imp_q + 1'b1);
            else if (upd_ok && imp_q > tgt)
                imp_q <= 6'(imp_q - 1'b1);
        end
    end

    // ====================
    // Status: sticky recovery, mode and capture-drop errors
    assign st_set = {cap_in.valid & ~cap_in.ready,
                     (sw_q & op != sscs_pkg::SSCS_DESEL)
                     | (mode_chg & desel_run_q < 6'(`SSCS_PRE_DESEL)),
                     (pwr_q == sscs_pkg::SSCS_RECOVER) & (op != sscs_pkg::SSCS_DESEL)};
    assign st_clr = (wr_go & wr_hot[1] & w_strb_q[0])
                    ? aw_data_q[`SSCS_STAT_STICKY +: 3] : 3'h0;
    assign stat_w = {25'h0, ~cap_out.valid, sticky_q, mode_s, cal_done_q, standby};

    // ====================
    // AXI4-Lite slave
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go  = aw_have_q & w_have_q;
    assign ar_go  = s_axi_arvalid & ~s_axi_rvalid;
    assign wr_hot = reg_hot(aw_addr_q);
    assign rd_hot = reg_hot(s_axi_araddr);
    assign rd_mux = ({32{rd_hot[0]}} & ctrl_q) | ({32{rd_hot[1]}} & stat_w)
                  | ({32{rd_hot[2] & cap_out.valid}} & cap_out.data)
                  | ({32{rd_hot[3]}} & {26'h0, imp_q});
    assign cap_out.ready = ar_go & rd_hot[2];

    // Write channel, registers and sticky bits; set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            aw_data_q    <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            ctrl_q       <= `SSCS_CTRL_RST;
            sticky_q     <= 3'h0;
        end else begin
            sticky_q <= st_set | (sticky_q & ~st_clr);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q  <= 1'b1;
                aw_data_q <= s_axi_wdata;
                w_strb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (|wr_hot) ? 2'h0 : 2'h2;
                for (int i = 0; i < 4; i++) begin
                    if (wr_hot[0] && w_strb_q[i])
                        ctrl_q[8*i +: 8] <= aw_data_q[8*i +: 8];
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (|rd_hot) ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ====================
    // Checks
    // sleep silences drivers and commands
    chk_sleep_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_s |-> dq_oe_n && op == sscs_pkg::SSCS_DESEL)
        else $error("sleep left drivers or commands active");
    chk_oe_gate: assert property (@(posedge clk) disable iff (!arst_n)
        output_enable_n |-> dq_oe_n)
        else $error("drivers on while output enable high");
    // write or deselect gives high impedance
    chk_write_hiz: assert property (@(posedge clk) disable iff (!arst_n)
        op != sscs_pkg::SSCS_READ |=> dq_oe_n)
        else $error("drivers on after write or deselect");
    chk_read_drive: assert property (@(posedge clk) disable iff (!arst_n)
        op == sscs_pkg::SSCS_READ ##1 (!output_enable_n && !sleep_request && !sleep_s)
        |-> !dq_oe_n)
        else $error("read data not driven next cycle");
    chk_write_lanes: assert property (@(posedge clk) disable iff (!arst_n)
        op == sscs_pkg::SSCS_WRITE |=> mem_we && wr_be_q == ~$past(byte_lane_write_enable_n))
        else $error("write lanes lost");
    // no array write deep in sleep
    chk_sleep_hold: assert property (@(posedge clk) disable iff (!arst_n)
        pwr_q == sscs_pkg::SSCS_SLEEP && $past(pwr_q) == sscs_pkg::SSCS_SLEEP |-> !mem_we)
        else $error("array written during sleep");
    // impedance moves only in its window
    chk_cal_window: assert property (@(posedge clk) disable iff (!arst_n)
        imp_q != $past(imp_q) |-> $past(upd_ok) && $past(dq_oe_n))
        else $error("impedance changed while driving");
    // settle flag at the cycle count
    chk_cal_done: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(cal_done_q) |-> $past(cal_cnt_q) == 14'(CAL_CYCLES - 1))
        else $error("calibration window wrong length");
    // switch window ends after the deselect count
    chk_mode_count: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(sw_q) |-> $past(sw_cnt_q) == 6'(`SSCS_POST_DESEL - 1))
        else $error("mode switch window wrong length");
endmodule
`default_nettype wire

/* File: tb/sscs_ctl_model.sv */
// Purpose: Controller model driving the SRAM command port
// Assumes: Commands change just after the rising clock edge
// Notes:   Data lines toggle on each command when no write data is due
`timescale 1ns/1ps
`default_nettype none
module sscs_ctl_model (
    input  wire logic        clk,
    output var  logic        chip_select_n,
    output var  logic        sync_write_enable_n,
    output var  logic [3:0]  byte_lane_write_enable_n,
    output var  logic [7:0]  sram_addr,
    output var  logic [31:0] dq_in
);
    logic        wr_q;
    logic [31:0] wd_q;
    // Idle bus at time zero
    initial begin
        chip_select_n = 1'b1;
        sync_write_enable_n = 1'b1;
        byte_lane_write_enable_n = 4'hF;
        sram_addr = 8'h00;
        dq_in = 32'h0;
        wr_q = 1'b0;
    end
    task automatic cmd(input logic c, input logic w, input logic [3:0] b,
                       input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        chip_select_n <= c;
        sync_write_enable_n <= w;
        byte_lane_write_enable_n <= b;
        sram_addr <= a;
        dq_in <= wr_q ? wd_q : ~dq_in;
        wr_q <= ~c & ~w;
        wd_q <= d;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the SRAM command and sleep control
// Assumes: Calibration count shortened to 16 cycles
// Notes:   Scenarios run in sequence, each judging its own results
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, chip_select_n, sync_write_enable_n, dq_oe_n, standby;
    logic output_enable_n, sleep_request, late_select_mode_pin;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, sram_addr;
    logic [31:0] s_axi_wdata, s_axi_rdata, dq_in, dq_out, rd_d;
    logic [3:0]  s_axi_wstrb, byte_lane_write_enable_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    logic [5:0]  impedance_code;
    int          error_cnt, cmp_count;
    sscs_top #(.CAL_CYCLES(16)) u_sscs_top (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .chip_select_n, .sync_write_enable_n, .byte_lane_write_enable_n, .sram_addr,
        .dq_in, .dq_out, .dq_oe_n, .output_enable_n, .sleep_request,
        .late_select_mode_pin, .impedance_code, .standby);
    sscs_ctl_model u_sscs_ctl_model (.clk, .chip_select_n, .sync_write_enable_n,
        .byte_lane_write_enable_n, .sram_addr, .dq_in);
    // ==========
    // Checking and closing
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========
    // Bus and command tasks
    // Each channel is judged at the rising edge and dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic pb;
        pb = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!pb) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            pb = s_axi_bvalid;
            wr_r = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic pr;
        pr = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!pr) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            pr = s_axi_rvalid;
            rd_d = s_axi_rdata;
            rd_r = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic dsel(input int n);
        repeat (n) u_sscs_ctl_model.cmd(1'b1, 1'b1, 4'hF, 8'h00, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        u_sscs_ctl_model.cmd(1'b0, 1'b0, b, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic oe);
        u_sscs_ctl_model.cmd(1'b0, 1'b1, 4'hF, a, 32'h0);
        #1 chk(dq_oe_n, 1'b1);
        dsel(1);
        #1 chk(dq_oe_n, oe);
        chk(dq_out, e);
        dsel(1);
        #1 chk(dq_oe_n, 1'b1);
    endtask
    task automatic rec_err;
        @(posedge clk) sleep_request <= 1'b1;
        dsel(6);
        @(posedge clk) sleep_request <= 1'b0;
        dsel(5);
        rd_chk(8'h02, 32'h2222_2222, 1'b0);
        axi_rd(8'h04);
        chk(rd_d[5:3], 3'b101);
        axi_wr(8'h04, 32'h0000_0038);
        chk(wr_r, 2'b00);
        axi_rd(8'h04);
        chk(rd_d[5:3], 3'b000);
    endtask
    // ==========
    // Clock, watchdog and scenarios
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        #50000;
        error_cnt++;
        end_sim;
    end
    initial begin
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
        {s_axi_rready, output_enable_n, sleep_request, late_select_mode_pin} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        axi_rd(8'h00);
        chk(rd_d, 32'h0000_2001);
        chk(impedance_code, 6'h20);
        for (int i = 0; i < 9; i++) wr(i[7:0], 4'h0, {8{i[3:0]}});
        dsel(2);
        axi_rd(8'h04);
        chk(rd_d[6:5], 2'b01);
        for (int i = 0; i < 8; i++) begin
            axi_rd(8'h08);
            chk(rd_d, {8{i[3:0]}});
        end
        axi_rd(8'h04);
        chk(rd_d[6], 1'b1);
        wr(8'h03, 4'hE, 32'hFFFF_FFFF);
        wr(8'h03, 4'hF, 32'h0);
        rd_chk(8'h03, 32'h3333_33FF, 1'b0);
        @(posedge clk) output_enable_n <= 1'b1;
        rd_chk(8'h05, 32'h5555_5555, 1'b1);
        @(posedge clk) output_enable_n <= 1'b0;
        dsel(2);
        @(posedge clk) sleep_request <= 1'b1;
        #1 chk(standby, 1'b1);
        dsel(4);
        wr(8'h03, 4'h0, 32'h0);
        rd_chk(8'h03, 32'h5555_5555, 1'b1);
        @(posedge clk) sleep_request <= 1'b0;
        dsel(8);
        rd_chk(8'h03, 32'h3333_33FF, 1'b0);
        dsel(2);
        @(posedge clk) late_select_mode_pin <= 1'b1;
        dsel(36);
        rd_chk(8'h02, 32'h2222_2222, 1'b0);
        axi_rd(8'h04);
        chk(rd_d[4:1], 4'b0011);
        axi_wr(8'h00, 32'h0000_1501);
        chk(wr_r, 2'b00);
        axi_rd(8'h00);
        chk(rd_d, 32'h0000_1501);
        dsel(24);
        chk(impedance_code, 6'h15);
        axi_rd(8'h10);
        chk(rd_r, 2'b10);
        rec_err;
        end_sim;
    end
endmodule
`default_nettype wire
